// ---- core/rsq_reset_sequencer.sv ----
// Notes on behaviour
// RL1 - System reset: 514 watchdog edges, 16 clocks (code: clock phase lasts 17 clocks).
// RL2 - Short reset: same, but 66 watchdog edges.
// RL3 - Core idle in reset; oscillators keep running.
// RL4 - System clock gated until watchdog count ends.
// RL5 - Control registers load defaults during reset.
// RL6 - Fetch vector from 0002H/0003H into PC.
// RL7 - Power-on/brown-out always wins, full system reset.
// RL8 - Watchdog reset in normal/halt gives short reset.
// RL9 - Pin resets depend on mode; stop gives system.
// RL10 - Debugger reset bit: system reset, debugger spared.
// RL11 - New source restarts count, keeps longer type.
`timescale 1ns/1ps
`default_nettype none

module rsq_reset_sequencer #(
    parameter int unsigned SYS_WDT_CYCLES = rsq_pkg::RSQ_SYS_WDT_CYCLES,
    parameter int unsigned SHORT_WDT_CYCLES = rsq_pkg::RSQ_SHORT_WDT_CYCLES,
    parameter int unsigned SCLK_CYCLES = rsq_pkg::RSQ_SCLK_CYCLES
) (
    input wire logic i_clk, // System clock, 20 MHz.
    input wire logic i_rstn, // Asynchronous reset, active low.
    input wire logic i_wdt_osc, // Watchdog oscillator level, sampled.
    input wire logic i_por_bor, // Power-on or brown-out event, high.
    input wire logic i_wdt_timeout, // Watchdog time-out, high.
    input wire logic i_wdt_rst_en, // Watchdog configured for reset.
    input wire logic i_reset_pin_n, // External reset pin, low asserts.
    input wire logic i_debug_pin, // Debug pin level, low asserts in stop.
    input wire logic i_stop_mode, // Device is in stop mode.
    input wire logic i_debug_control_wr, // Debugger writes debug_control_reg.
    input wire logic [7:0] i_debug_control_reg, // Value written.
    input wire logic [7:0] i_pmem_data, // Program memory data, one clock late.
    output logic o_core_rst, // CPU and peripherals held in reset.
    output logic o_ctrl_load, // Load control register defaults.
    output logic o_ocd_rst, // On-chip debugger held in reset.
    output logic o_sysclk_en, // System clock running.
    output logic o_osc_run, // Crystal and watchdog oscillators enabled.
    output logic o_rst_type, // High for system reset, low for short.
    output logic o_pmem_rd, // Program memory read strobe.
    output logic [15:0] o_pmem_addr, // Program memory address.
    output logic [15:0] o_pc, // Program counter load value.
    output logic o_pc_load, // One-cycle pulse: load o_pc.
    output logic o_cpu_run // CPU may execute.
);
    import rsq_pkg::*;

    localparam logic [RSQ_CNT_W-1:0] SYS_LIM = RSQ_CNT_W'(SYS_WDT_CYCLES);
    localparam logic [RSQ_CNT_W-1:0] SHORT_LIM = RSQ_CNT_W'(SHORT_WDT_CYCLES);
    localparam logic [RSQ_CNT_W-1:0] SCLK_LIM = RSQ_CNT_W'(SCLK_CYCLES);

    rsq_state_e state_r, state_nxt;
    logic type_r, type_nxt;
    logic ocd_r, ocd_nxt;
    logic wdt_prev_r;
    logic [7:0] vec_hi_r;
    logic [15:0] pc_r;
    logic pc_load_r;
    logic [RSQ_CNT_W-1:0] cnt;
    logic cnt_done;

    // Source classification by operating mode; power-on dominates all.
    wire dbg_req = i_debug_control_wr && i_debug_control_reg[RSQ_DBG_RST_BIT]; // RL10
    wire stop_req = i_stop_mode && (!i_reset_pin_n || !i_debug_pin); // RL9
    wire wdt_req = !i_stop_mode && i_wdt_timeout && i_wdt_rst_en; // RL8
    wire pin_req = !i_stop_mode && !i_reset_pin_n; // RL9
    wire sys_req = i_por_bor || stop_req || dbg_req; // RL7
    wire any_req = sys_req || wdt_req || pin_req;
    wire in_seq = (state_r != RSQ_ST_RUN);
    wire wdt_rise = i_wdt_osc && !wdt_prev_r;
    wire in_wdt = (state_r == RSQ_ST_WDT);
    wire phase_end = (in_wdt || state_r == RSQ_ST_SCLK) && cnt_done;

    // A request inside a sequence keeps the longer type already running.
    assign type_nxt = any_req ? (sys_req || (in_seq && type_r)) : type_r; // RL11
    // Only power-on and stop-mode pin resets reach the debugger.
    assign ocd_nxt = any_req ? (i_por_bor || stop_req || (in_seq && ocd_r)) : (ocd_r && in_seq); // RL10

    // The watchdog phase counts oscillator edges, then the clock phase counts clocks.
    rsq_tick_counter #(
        .W(RSQ_CNT_W)
    ) u_cnt (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_clear(any_req || phase_end), // RL11
        .i_tick(in_wdt ? wdt_rise : 1'b1),
        .i_limit(in_wdt ? (type_r ? SYS_LIM : SHORT_LIM) : SCLK_LIM), // RL1 RL2
        .o_count(cnt),
        .o_done(cnt_done)
    );

    // Next state; any new source sends the sequence back to the start.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            RSQ_ST_WDT: begin
                if (cnt_done) begin
                    state_nxt = RSQ_ST_SCLK; // RL4
                end
            end
            RSQ_ST_SCLK: begin
                if (cnt_done) begin
                    state_nxt = RSQ_ST_FETCH_HI; // RL1
                end
            end
            RSQ_ST_FETCH_HI: state_nxt = RSQ_ST_FETCH_LO;
            RSQ_ST_FETCH_LO: state_nxt = RSQ_ST_LOAD;
            RSQ_ST_LOAD: state_nxt = RSQ_ST_RUN;
            RSQ_ST_RUN: state_nxt = RSQ_ST_RUN;
            default: state_nxt = RSQ_ST_WDT;
        endcase
        if (any_req) begin
            state_nxt = RSQ_ST_WDT; // RL7 RL11
        end
    end

    // Sequencer state and reset type; chip reset counts as a system reset.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= RSQ_ST_WDT;
            type_r <= RSQ_TYPE_SYSTEM;
            ocd_r <= 1'b1;
            wdt_prev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            type_r <= type_nxt;
            ocd_r <= ocd_nxt;
            wdt_prev_r <= i_wdt_osc;
        end
    end

    // Vector capture: memory answers one clock after the address.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            vec_hi_r <= 8'h00;
            pc_r <= RSQ_PC_RESET;
            pc_load_r <= 1'b0;
        end else begin
            pc_load_r <= (state_r == RSQ_ST_LOAD) && !any_req; // RL6
            if (state_r == RSQ_ST_FETCH_LO) begin
                vec_hi_r <= i_pmem_data; // RL6
            end
            if (state_r == RSQ_ST_LOAD) begin
                pc_r <= {vec_hi_r, i_pmem_data}; // RL6
            end
        end
    end

    // Outputs decode the sequencer registers; core reset and CPU run also see new requests directly.
    assign o_core_rst = in_seq || any_req; // RL3
    assign o_ctrl_load = (state_r == RSQ_ST_WDT) || (state_r == RSQ_ST_SCLK); // RL5
    assign o_ocd_rst = ocd_r;
    assign o_sysclk_en = !in_wdt; // RL4
    assign o_osc_run = 1'b1; // RL3
    assign o_rst_type = type_r;
    assign o_pmem_rd = (state_r == RSQ_ST_FETCH_HI) || (state_r == RSQ_ST_FETCH_LO); // RL6
    assign o_pmem_addr = (state_r == RSQ_ST_FETCH_LO) ? RSQ_VEC_ADDR_LO : RSQ_VEC_ADDR_HI; // RL6
    assign o_pc = pc_r;
    assign o_pc_load = pc_load_r;
    assign o_cpu_run = (state_r == RSQ_ST_RUN) && !any_req;

    AST_SYS_WDT_LEN: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL1
        (state_r == RSQ_ST_WDT && !any_req && type_r) ##1 (state_r == RSQ_ST_SCLK)
        |-> $past(cnt) == SYS_LIM) else $error("System watchdog phase length wrong.");

    AST_SHORT_WDT_LEN: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL2
        (state_r == RSQ_ST_WDT && !any_req && !type_r) ##1 (state_r == RSQ_ST_SCLK)
        |-> $past(cnt) == SHORT_LIM) else $error("Short watchdog phase length wrong.");

    // Helper for the clock-phase checks: clocks spent so far in the clock phase.
    // A long repetition would be costly to check, so a small counter keeps the tally instead.
    logic [RSQ_CNT_W-1:0] sclk_seen_r;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sclk_seen_r <= '0;
        end else if (state_r == RSQ_ST_SCLK && !any_req) begin
            sclk_seen_r <= RSQ_CNT_W'(sclk_seen_r + 1'b1);
        end else begin
            sclk_seen_r <= '0;
        end
    end

    AST_SCLK_LEN: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL1
        (state_r == RSQ_ST_SCLK && !any_req && sclk_seen_r == SCLK_LIM) |=> (state_r == RSQ_ST_FETCH_HI))
        else $error("Clock phase did not end after its count.");

    AST_SCLK_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL4
        (state_r == RSQ_ST_SCLK && !any_req && sclk_seen_r < SCLK_LIM) |=> (state_r == RSQ_ST_SCLK && o_core_rst))
        else $error("Clock phase ended early.");

    AST_IDLE_IN_RESET: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL3
        (state_r != RSQ_ST_RUN) |-> (o_core_rst && o_osc_run && !o_cpu_run))
        else $error("Core released or oscillator stopped during reset.");

    AST_CLOCK_GATED: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL4
        (state_r == RSQ_ST_WDT) |-> (!o_sysclk_en && o_core_rst))
        else $error("System clock ran during watchdog phase.");

    AST_VECTOR_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL6
        (state_r == RSQ_ST_FETCH_HI && o_pmem_addr == RSQ_VEC_ADDR_HI && !any_req) ##1
        (o_pmem_addr == RSQ_VEC_ADDR_LO && !any_req) ##1 !any_req
        |=> o_pc_load && o_pc[7:0] == $past(i_pmem_data, 1) && o_pc[15:8] == $past(i_pmem_data, 2))
        else $error("Reset vector not loaded from 0002H and 0003H.");

    AST_POR_SYSTEM: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL7
        i_por_bor |=> (type_r && o_ocd_rst && state_r == RSQ_ST_WDT && cnt == '0))
        else $error("Power-on did not start a full system reset.");

    AST_WDT_SHORT: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL8
        (state_r == RSQ_ST_RUN && wdt_req && !sys_req) |=> (!type_r && state_r == RSQ_ST_WDT))
        else $error("Watchdog reset was not short.");

    AST_STOP_PIN_SYSTEM: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL9
        (i_stop_mode && (!i_reset_pin_n || !i_debug_pin)) |=> type_r)
        else $error("Stop-mode pin reset was not a system reset.");

    AST_DEBUG_SPARED: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL10
        (state_r == RSQ_ST_RUN && dbg_req && !i_por_bor && !stop_req) |=> (type_r && !o_ocd_rst))
        else $error("Debugger reset touched the debugger.");

    AST_RESTART: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL11
        (any_req && type_r && in_seq) |=> (state_r == RSQ_ST_WDT && cnt == '0 && type_r))
        else $error("Restart lost count or reset type.");

endmodule

`default_nettype wire

// ---- core/rsq_pkg.sv ----
package rsq_pkg;

    // Reset phase lengths, in watchdog-oscillator edges and system clocks.
    localparam int unsigned RSQ_SYS_WDT_CYCLES = 514;
    localparam int unsigned RSQ_SHORT_WDT_CYCLES = 66;
    localparam int unsigned RSQ_SCLK_CYCLES = 16;
    localparam int unsigned RSQ_CNT_W = 10;

    // Reset vector locations in program memory.
    localparam logic [15:0] RSQ_VEC_ADDR_HI = 16'h0002;
    localparam logic [15:0] RSQ_VEC_ADDR_LO = 16'h0003;
    localparam logic [15:0] RSQ_PC_RESET = 16'h0000;

    // Bit of debug_control_reg that requests a reset.
    localparam int unsigned RSQ_DBG_RST_BIT = 1;

    // Reset type encoding.
    localparam logic RSQ_TYPE_SYSTEM = 1'b1;
    localparam logic RSQ_TYPE_SHORT = 1'b0;

    // Sequencer states, Gray coded along the release path.
    typedef enum logic [2:0] {
        RSQ_ST_WDT = 3'h0,
        RSQ_ST_SCLK = 3'h1,
        RSQ_ST_FETCH_HI = 3'h3,
        RSQ_ST_FETCH_LO = 3'h2,
        RSQ_ST_LOAD = 3'h6,
        RSQ_ST_RUN = 3'h7
    } rsq_state_e;

endpackage

// ---- core/rsq_tick_counter.sv ----
`timescale 1ns/1ps
`default_nettype none

module rsq_tick_counter #(
    parameter int unsigned W = 10
) (
    input wire logic i_clk, // System clock.
    input wire logic i_rstn, // Asynchronous reset, active low.
    input wire logic i_clear, // Restart the count from zero.
    input wire logic i_tick, // Count one event.
    input wire logic [W-1:0] i_limit, // Terminal count.
    output logic [W-1:0] o_count, // Current count.
    output logic o_done // Count has reached the limit.
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // The count saturates at the limit so a late tick cannot overshoot.
    assign o_done = (cnt_r == i_limit);
    assign o_count = cnt_r;
    assign cnt_nxt = i_clear ? '0 : ((i_tick && !o_done) ? W'(cnt_r + 1'b1) : cnt_r);

    // Count register.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- sim/rsq_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: watchdog oscillator and program memory with one clock of latency.
module rsq_far_model (
    input wire logic i_clk, // System clock.
    input wire logic i_rstn, // Reset, active low.
    input wire logic i_pmem_rd, // Read strobe.
    input wire logic [15:0] i_pmem_addr, // Read address.
    output logic o_wdt_osc, // Oscillator level, one rise per four clocks.
    output logic [7:0] o_pmem_data // Read data.
);
    logic [1:0] div_r;
    assign o_wdt_osc = div_r[1];
    // A released data bus flips every cycle so stale bytes are never reused.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_r <= 2'h0;
            o_pmem_data <= 8'h00;
        end else begin
            div_r <= div_r + 2'h1;
            if (i_pmem_rd) begin
                o_pmem_data <= (i_pmem_addr == 16'h0002) ? 8'hA5 : (i_pmem_addr == 16'h0003) ? 8'h3C : 8'h00;
            end else begin
                o_pmem_data <= ~o_pmem_data;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/reset_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer_tb_top;
    import rsq_pkg::*;
    localparam int SYS_N = 8;
    localparam int SHORT_N = 4;
    localparam int SCLK_N = 4;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic osc, por, wto, wen, pin_n, dpin, stop, dwr, prev_osc;
    logic core_rst, ctrl_load, ocd_rst, sclk_en, osc_run, rtype, prd, pc_load, cpu_run;
    logic [7:0] dreg, pdata;
    logic [15:0] paddr, pc;
    int err_count = 0;
    int comparisons = 0;
    always #25 i_clk = ~i_clk;
    rsq_reset_sequencer #(.SYS_WDT_CYCLES(SYS_N), .SHORT_WDT_CYCLES(SHORT_N), .SCLK_CYCLES(SCLK_N)) DUT (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_wdt_osc(osc), .i_por_bor(por), .i_wdt_timeout(wto),
        .i_wdt_rst_en(wen), .i_reset_pin_n(pin_n), .i_debug_pin(dpin), .i_stop_mode(stop),
        .i_debug_control_wr(dwr), .i_debug_control_reg(dreg), .i_pmem_data(pdata),
        .o_core_rst(core_rst), .o_ctrl_load(ctrl_load), .o_ocd_rst(ocd_rst), .o_sysclk_en(sclk_en),
        .o_osc_run(osc_run), .o_rst_type(rtype), .o_pmem_rd(prd), .o_pmem_addr(paddr), .o_pc(pc),
        .o_pc_load(pc_load), .o_cpu_run(cpu_run));
    rsq_far_model FAR (.i_clk(i_clk), .i_rstn(i_rstn), .i_pmem_rd(prd), .i_pmem_addr(paddr),
        .o_wdt_osc(osc), .o_pmem_data(pdata));
    // Verdict and counts; also reached when a wait runs out.
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // One-cycle request; v = {por, timeout, wdt_en, pin low, debug pin low, stop, debugger write}.
    task automatic fire(input logic [6:0] v, input logic [7:0] d);
        @(posedge i_clk) #1;
        {por, wto, wen, pin_n, dpin, stop, dwr} = v ^ 7'b0001100;
        dreg = d;
        @(negedge i_clk) prev_osc = osc;
        @(posedge i_clk) #1;
        {por, wto, wen, pin_n, dpin, stop, dwr} = 7'b0001100;
    endtask
    // Follows one sequence to release and judges every phase of it.
    task automatic run_seq(input int n, input logic ty, input logic ocd);
        int rises, sclk, nrd, t;
        logic [15:0] fa [2];
        rises = 0;
        sclk = 0;
        nrd = 0;
        for (t = 0; t < 2000 && cpu_run !== 1'b1; t++) begin
            @(negedge i_clk);
            if (t == 0) chk(rtype === ty && ocd_rst === ocd, "reset type or debugger reset");
            chk(osc_run === 1'b1 && (cpu_run === 1'b1 || core_rst === 1'b1), "core or oscillator");
            if (sclk_en === 1'b0) begin
                chk(ctrl_load === 1'b1, "defaults not loading");
                rises += int'(osc && !prev_osc);
            end
            if (sclk_en === 1'b1 && core_rst === 1'b1 && prd === 1'b0 && nrd == 0) begin
                sclk++;
                chk(ctrl_load === 1'b1, "defaults not loading in clock phase");
            end
            if (prd === 1'b1 && nrd < 2) fa[nrd] = paddr;
            if (prd === 1'b1) nrd++;
            prev_osc = osc;
        end
        if (cpu_run !== 1'b1) begin
            chk(1'b0, "sequence hung");
            tally_and_finish();
        end
        chk(rises == n, "watchdog phase length");
        chk(sclk == SCLK_N + 1, "clock phase length");
        chk(nrd == 2 && fa[0] === RSQ_VEC_ADDR_HI && fa[1] === RSQ_VEC_ADDR_LO, "vector fetch");
        chk(pc === 16'hA53C && pc_load === 1'b1 && core_rst === 1'b0, "vector load");
        chk(ctrl_load === 1'b0, "defaults still loading after release");
        @(negedge i_clk);
        chk(pc_load === 1'b0 && cpu_run === 1'b1, "load pulse");
    endtask
    task automatic no_reset(input logic [6:0] v, input logic [7:0] d);
        fire(v, d);
        repeat (3) @(negedge i_clk);
        chk(cpu_run === 1'b1 && core_rst === 1'b0, "spurious reset");
    endtask
    task automatic test_normal_mode();
        fire(7'b1001000, 8'h00);
        run_seq(SYS_N, RSQ_TYPE_SYSTEM, 1'b1);
        fire(7'b0110000, 8'h00);
        run_seq(SHORT_N, RSQ_TYPE_SHORT, 1'b0);
        fire(7'b0001000, 8'h00);
        run_seq(SHORT_N, RSQ_TYPE_SHORT, 1'b0);
        no_reset(7'b0100000, 8'h00);
        no_reset(7'b0110010, 8'h00);
        no_reset(7'b0000100, 8'h00);
        $display("test normal_mode done");
    endtask
    task automatic test_stop_and_debug();
        fire(7'b0001010, 8'h00);
        run_seq(SYS_N, RSQ_TYPE_SYSTEM, 1'b1);
        fire(7'b0000110, 8'h00);
        run_seq(SYS_N, RSQ_TYPE_SYSTEM, 1'b1);
        fire(7'b0000001, 8'h02);
        run_seq(SYS_N, RSQ_TYPE_SYSTEM, 1'b0);
        no_reset(7'b0000001, 8'hFD);
        $display("test stop_and_debug done");
    endtask
    // A short request early in a system sequence must restart it yet keep it long.
    task automatic test_restart();
        fire(7'b1000000, 8'h00);
        repeat (10) @(negedge i_clk);
        fire(7'b0001000, 8'h00);
        run_seq(SYS_N, RSQ_TYPE_SYSTEM, 1'b1);
        $display("test restart done");
    endtask
    // A chip reset in mid-run must clear everything and replay a full system sequence.
    task automatic test_mid_reset();
        @(posedge i_clk) #1;
        i_rstn = 1'b0;
        @(negedge i_clk) prev_osc = osc;
        chk(core_rst === 1'b1 && cpu_run === 1'b0 && pc === RSQ_PC_RESET && pc_load === 1'b0, "chip reset outputs");
        @(posedge i_clk) #1;
        i_rstn = 1'b1;
        run_seq(SYS_N, RSQ_TYPE_SYSTEM, 1'b1);
        $display("test mid_reset done");
    endtask
    initial begin
        {por, wto, wen, pin_n, dpin, stop, dwr} = 7'b0001100;
        dreg = 8'h00;
        prev_osc = 1'b0;
        repeat (3) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        run_seq(SYS_N, RSQ_TYPE_SYSTEM, 1'b1);
        $display("test power_up done");
        test_normal_mode();
        test_stop_and_debug();
        test_restart();
        test_mid_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
